// [sim/smfl_chk.sv]
// Port checker for the supply monitor flag logic.
// Assumes clk_en_in stays high and reads are at the control address.
module smfl_chk
  import smfl_pkg::*;
#(
  parameter longint HOLDOFF_CYC = 20
)
(
  input wire logic       sys_clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic       sfr_wr_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       digital_cmp_raw_in,
  input wire logic       analog_cmp_raw_in,
  input wire logic       monitor_irq_enable_in,
  input wire logic [1:0] digital_trip_sel_out,
  input wire logic [1:0] analog_trip_sel_out,
  input wire logic       comparator_enable_out,
  input wire logic       supply_irq_out,
  input wire logic       watchdog_enable_clear_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] dlo_reg, dlo_next, ahi_reg, ahi_next;
  logic       sel_hit;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Saturating run counters of raw comparator levels
  always_comb begin
    sel_hit  = sfr_addr_in == SMFL_CTRL_ADDR;
    dlo_next = (comparator_enable_out && !digital_cmp_raw_in) ? dlo_reg + (dlo_reg != 3'h7) : 3'h0;
    ahi_next = analog_cmp_raw_in ? ahi_reg + (ahi_reg != 3'h7) : 3'h0;
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dlo_reg <= 3'h0;
      ahi_reg <= 3'h0;
    end else begin
      dlo_reg <= dlo_next;
      ahi_reg <= ahi_next;
    end
  end
  sequence s_ctrl_wr;
    sfr_wr_in && sel_hit;
  endsequence
  a_trip_write: assert property (s_ctrl_wr |=>
    {digital_trip_sel_out, analog_trip_sel_out} ==
    {$past(sfr_wdata_in[4:3]), $past(sfr_wdata_in[2:1])}) else $error("trip select wrong");
  a_enable_write: assert property (s_ctrl_wr |=>
    comparator_enable_out == $past(sfr_wdata_in[0])) else $error("enable wrong");
  a_reset_value: assert property ($rose(rst_n_in) |->
    digital_trip_sel_out == 2'h3 && analog_trip_sel_out == 2'h3 && !comparator_enable_out)
    else $error("reset fields wrong");
  a_read_fields: assert property (sel_hit |=> sfr_rdata_out[4:0] ==
    $past({digital_trip_sel_out, analog_trip_sel_out, comparator_enable_out}))
    else $error("read fields wrong");
  a_ana_bit_live: assert property (ahi_reg == 3'h7 && sel_hit |=>
    sfr_rdata_out[SMFL_BIT_ANA_OK]) else $error("analog bit low");
  a_fault_raises: assert property (dlo_reg == 3'h7 && monitor_irq_enable_in |=>
    supply_irq_out) else $error("fault missed");
  a_irq_needs_en: assert property (!monitor_irq_enable_in |=> !supply_irq_out)
    else $error("irq without enable");
  a_wd_clear_irq: assert property (watchdog_enable_clear_out == supply_irq_out)
    else $error("watchdog clear differs");
endmodule
bind smfl_top smfl_chk #(.HOLDOFF_CYC(HOLDOFF_CYC)) u_chk (.sys_clk_in, .rst_n_in,
  .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rdata_out, .digital_cmp_raw_in,
  .analog_cmp_raw_in, .monitor_irq_enable_in, .digital_trip_sel_out,
  .analog_trip_sel_out, .comparator_enable_out, .supply_irq_out, .watchdog_enable_clear_out);

// [sim/smfl_top_test.sv]
// Self-checking bench for the supply monitor flag logic.
// Assumes the bound checker; clock enable held high throughout.
module smfl_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import smfl_pkg::*;
  localparam int HO = 20;
  // Scenarios take about 200 cycles; a run five times as long has hung
  localparam int LIMIT_CYC = 1000;
  logic       clk = 0, rst_n = 0, wr = 0, dr = 1, ar = 1, ie = 1, en, irq, wdc;
  logic [7:0] addr = 8'h00, wd = 8'h00, rd, q, w;
  logic [1:0] dsel, asel;
  int         errors = 0, tests_run = 0, seed = 32'h2CC592F7;
  always #5 clk = ~clk;
  smfl_top #(.HOLDOFF_CYC(HO)) dut (.sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1),
    .sfr_addr_in(addr), .sfr_wdata_in(wd), .sfr_wr_in(wr), .sfr_rdata_out(rd),
    .digital_cmp_raw_in(dr), .analog_cmp_raw_in(ar), .monitor_irq_enable_in(ie),
    .digital_trip_sel_out(dsel), .analog_trip_sel_out(asel), .comparator_enable_out(en),
    .supply_irq_out(irq), .watchdog_enable_clear_out(wdc));
  function automatic logic [7:0] ctrl(logic d, logic a, logic f, logic [4:0] fld);
    return {d, a, f, fld};
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1;
    cyc(1);
    wr = 0;
  endtask
  task automatic rreg();
    addr = SMFL_CTRL_ADDR;
    cyc(1);
    q = rd;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (LIMIT_CYC) @(posedge clk);
    errors++;
    $display("BAD watchdog exp finished got timeout");
    tally_and_finish();
  end
  initial begin
    cyc(4);
    rst_n = 1;
    cyc(1);
    rreg();
    chk("reset", SMFL_CTRL_RESET, q);
    for (int k = 0; k < 8; k++) begin
      w = (8'($random(seed)) & 8'hC1) | {3'h0, k[1:0], ~k[1:0], 1'b0};
      wreg(SMFL_CTRL_ADDR, w);
      // Let one edge pass so the strobe is not raised again in the step it fell
      cyc(1);
      wreg(8'hDE, ~w);
      rreg();
      chk("ctrl", ctrl(1, 1, 0, w[4:0]), q);
      chk("dsel", {6'h0, w[4:3]}, {6'h0, dsel});
      chk("asel", {6'h0, w[2:1]}, {6'h0, asel});
      chk("en", {7'h0, w[0]}, {7'h0, en});
    end
    addr = 8'h10;
    cyc(1);
    chk("other", 8'h00, rd);
    $display("test fields done");
    wreg(SMFL_CTRL_ADDR, 8'h01);
    cyc(8);
    dr = 0;
    cyc(3);
    dr = 1;
    cyc(8);
    rreg();
    chk("glitch", ctrl(1, 1, 0, 5'h01), q);
    chk("glitchirq", 8'h00, {7'h0, irq});
    ar = 0;
    cyc(10);
    rreg();
    chk("fault", ctrl(1, 0, 1, 5'h01), q);
    chk("irq", 8'h01, {7'h0, irq});
    chk("wdclr", 8'h01, {7'h0, wdc});
    wreg(SMFL_CTRL_ADDR, 8'h01);
    rreg();
    chk("nozero", ctrl(1, 0, 1, 5'h01), q);
    ie = 0;
    cyc(2);
    chk("masked", 8'h00, {7'h0, irq});
    chk("wdmasked", 8'h00, {7'h0, wdc});
    ie = 1;
    $display("test fault done");
    ar = 1;
    cyc(HO / 2);
    dr = 0;
    cyc(6);
    dr = 1;
    cyc(HO - 6);
    rreg();
    chk("holding", ctrl(1, 1, 1, 5'h01), q);
    cyc(15);
    rreg();
    chk("cleared", ctrl(1, 1, 0, 5'h01), q);
    chk("irqoff", 8'h00, {7'h0, irq});
    dr = 0;
    cyc(10);
    rreg();
    chk("dfault", ctrl(0, 1, 1, 5'h01), q);
    chk("dirq", 8'h01, {7'h0, irq});
    // Filter window, one edge to start, then the full hold-off count
    dr = 1;
    cyc(SMFL_GLITCH_CYC + HO + 1);
    chk("holdend", ctrl(1, 1, 1, 5'h01), rd);
    chk("holdirq", 8'h01, {7'h0, irq});
    cyc(1);
    chk("holddone", ctrl(1, 1, 0, 5'h01), rd);
    chk("holdirqoff", 8'h00, {7'h0, irq});
    $display("test holdoff done");
    wreg(SMFL_CTRL_ADDR, 8'h21);
    rreg();
    chk("swset", ctrl(1, 1, 1, 5'h01), q);
    wreg(SMFL_CTRL_ADDR, 8'h01);
    rreg();
    chk("swclr", ctrl(1, 1, 0, 5'h01), q);
    wreg(SMFL_CTRL_ADDR, 8'h00);
    ar = 0;
    cyc(12);
    rreg();
    chk("off", ctrl(1, 1, 0, 5'h00), q);
    ar = 1;
    $display("test software done");
    rst_n = 0;
    cyc(2);
    rst_n = 1;
    cyc(1);
    rreg();
    chk("rereset", SMFL_CTRL_RESET, q);
    $display("test reset done");
    tally_and_finish();
  end
endmodule

// [verilog/smfl_cmp_if.sv]
// Carries one filtered comparator result from a filter to the top.
// Assumes a single clock domain.
interface smfl_cmp_if;
  logic ok;
  modport src (output ok);
  modport dst (input ok);
endinterface

// [verilog/smfl_glitch_filter.sv]
// Glitch filter for one comparator output.
// Assumes the raw comparator level is synchronous to the clock.
module smfl_glitch_filter
  import smfl_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  input  wire logic clk_en_in,
  input  wire logic raw_ok_in,
  smfl_cmp_if.src   cmp
);
  logic [SMFL_GLT_W-1:0] cnt_reg;
  logic [SMFL_GLT_W-1:0] cnt_next;
  logic                  ok_reg;
  logic                  ok_next;

  // A new level must persist for the full window before it is accepted
  always_comb begin
    cnt_next = cnt_reg;
    ok_next  = ok_reg;
    if (raw_ok_in == ok_reg) begin
      cnt_next = '0;
    end else if (cnt_reg == SMFL_GLT_W'(SMFL_GLITCH_CYC - 1)) begin
      ok_next  = raw_ok_in;
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + SMFL_GLT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
      ok_reg  <= 1'b1;
    end else if (clk_en_in) begin
      cnt_reg <= cnt_next;
      ok_reg  <= ok_next;
    end
  end

  assign cmp.ok = ok_reg;
endmodule

// [verilog/smfl_pkg.sv]
// Constants for the supply monitor flag logic: register map, fields, timing.
// Assumes a 100 MHz core clock and an 8-bit special-function register port.
package smfl_pkg;
  localparam logic [7:0] SMFL_CTRL_ADDR     = 8'hDF;
  localparam logic [7:0] SMFL_CTRL_RESET    = 8'hDE;
  localparam int         SMFL_BIT_DIG_OK    = 7;
  localparam int         SMFL_BIT_ANA_OK    = 6;
  localparam int         SMFL_BIT_FAULT     = 5;
  localparam int         SMFL_BIT_DTRIP_HI  = 4;
  localparam int         SMFL_BIT_DTRIP_LO  = 3;
  localparam int         SMFL_BIT_ATRIP_HI  = 2;
  localparam int         SMFL_BIT_ATRIP_LO  = 1;
  localparam int         SMFL_BIT_ENABLE    = 0;
  localparam logic [1:0] SMFL_TRIP_RESET    = 2'h3;
  localparam int         SMFL_CLK_HZ        = 100_000_000;
  localparam int         SMFL_HOLDOFF_MS    = 250;
  localparam longint     SMFL_HOLDOFF_CYC   = longint'(SMFL_CLK_HZ) * SMFL_HOLDOFF_MS / 1000;
  localparam int         SMFL_GLITCH_CYC    = 4;
  localparam int         SMFL_CNT_W         = 25;
  localparam int         SMFL_GLT_W         = 3;
endpackage

// [verilog/smfl_top.sv]
// Supply monitor flag logic: control/status register, fault flag, hold-off.
// Assumes analog comparators outside, driven by the trip selects, and a
// special-function register port from the core, all on one clock.
// Summary of operation
// - When enabled, both supplies are watched and a low one against its selected trip flags a fault.
// - The fault requests an interrupt only when the monitor interrupt enable is set.
// - Once both comparators are high a hold-off count runs and clears the flag if they stay high.
// - Short glitches on the comparator outputs are filtered out before they reach the flag.
// - Bit 7 reads the digital comparator and bit 6 the analog one, both read-only.
// - The fault flag in bit 5 is set whenever either comparator bit is low.
// - Software writes to the flag take effect, but a zero is ignored while a comparator is low.
// - Bits 4:3 select the digital trip level, 00 highest up to 11 lowest.
// - Bits 2:1 select the analog trip level with the same coding.
// - Bit 0 enables the monitor when written one and disables it when written zero.
// - After reset the register reads DEH.
// - A monitor interrupt clears the watchdog enable bit.
module smfl_top
  import smfl_pkg::*;
#(
  parameter longint HOLDOFF_CYC = smfl_pkg::SMFL_HOLDOFF_CYC
)
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       clk_en_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_wr_in,
  output logic [7:0]      sfr_rdata_out,
  input  wire logic       digital_cmp_raw_in,
  input  wire logic       analog_cmp_raw_in,
  input  wire logic       monitor_irq_enable_in,
  output logic [1:0]      digital_trip_sel_out,
  output logic [1:0]      analog_trip_sel_out,
  output logic            comparator_enable_out,
  output logic            supply_irq_out,
  output logic            watchdog_enable_clear_out
);
  import smfl_pkg::*;

  smfl_cmp_if dig_if ();
  smfl_cmp_if ana_if ();

  logic       dig_raw;
  logic       ana_raw;
  logic       monitor_enable_reg;
  logic       monitor_enable_next;
  logic [1:0] dtrip_reg;
  logic [1:0] dtrip_next;
  logic [1:0] atrip_reg;
  logic [1:0] atrip_next;
  logic       supply_fault_flag_reg;
  logic       supply_fault_flag_next;
  logic [SMFL_CNT_W-1:0] hold_cnt_reg;
  logic [SMFL_CNT_W-1:0] hold_cnt_next;
  logic       holding_reg;
  logic       holding_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       irq_reg;
  logic       irq_next;
  logic       wd_clr_reg;
  logic       wd_clr_next;
  logic       digital_supply_ok;
  logic       analog_supply_ok;
  logic       both_ok;
  logic       ctrl_wr;

  // Disabled comparators read as good, so a disabled monitor never faults
  assign dig_raw = digital_cmp_raw_in | ~monitor_enable_reg;
  assign ana_raw = analog_cmp_raw_in | ~monitor_enable_reg;

  smfl_glitch_filter u_dig_filter (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .clk_en_in  (clk_en_in),
    .raw_ok_in  (dig_raw),
    .cmp        (dig_if.src)
  );

  smfl_glitch_filter u_ana_filter (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .clk_en_in  (clk_en_in),
    .raw_ok_in  (ana_raw),
    .cmp        (ana_if.src)
  );

  assign digital_supply_ok = dig_if.ok;
  assign analog_supply_ok  = ana_if.ok;
  assign both_ok           = digital_supply_ok & analog_supply_ok;
  assign ctrl_wr           = sfr_wr_in && (sfr_addr_in == SMFL_CTRL_ADDR);

  // Control fields
  always_comb begin
    monitor_enable_next = monitor_enable_reg;
    dtrip_next          = dtrip_reg;
    atrip_next          = atrip_reg;
    if (ctrl_wr) begin
      monitor_enable_next = sfr_wdata_in[SMFL_BIT_ENABLE];
      dtrip_next = sfr_wdata_in[SMFL_BIT_DTRIP_HI:SMFL_BIT_DTRIP_LO];
      atrip_next = sfr_wdata_in[SMFL_BIT_ATRIP_HI:SMFL_BIT_ATRIP_LO];
    end
  end

  // Fault flag and hold-off counter; hardware set wins over a software clear
  always_comb begin
    supply_fault_flag_next = supply_fault_flag_reg;
    hold_cnt_next          = hold_cnt_reg;
    holding_next           = holding_reg;
    if (ctrl_wr) begin
      supply_fault_flag_next = sfr_wdata_in[SMFL_BIT_FAULT];
    end
    if (!both_ok) begin
      supply_fault_flag_next = 1'b1;
      holding_next           = 1'b0;
      hold_cnt_next          = '0;
    end else if (supply_fault_flag_reg && !holding_reg) begin
      holding_next  = 1'b1;
      hold_cnt_next = '0;
    end else if (holding_reg) begin
      if (hold_cnt_reg == SMFL_CNT_W'(HOLDOFF_CYC - 1)) begin
        supply_fault_flag_next = 1'b0;
        holding_next           = 1'b0;
        hold_cnt_next          = '0;
      end else begin
        hold_cnt_next = hold_cnt_reg + SMFL_CNT_W'(1);
      end
    end
  end

  // Read data, interrupt and watchdog clear, all registered
  always_comb begin
    rdata_next = 8'h00;
    if (sfr_addr_in == SMFL_CTRL_ADDR) begin
      rdata_next[SMFL_BIT_DIG_OK] = digital_supply_ok;
      rdata_next[SMFL_BIT_ANA_OK] = analog_supply_ok;
      rdata_next[SMFL_BIT_FAULT]  = supply_fault_flag_reg;
      rdata_next[SMFL_BIT_DTRIP_HI:SMFL_BIT_DTRIP_LO] = dtrip_reg;
      rdata_next[SMFL_BIT_ATRIP_HI:SMFL_BIT_ATRIP_LO] = atrip_reg;
      rdata_next[SMFL_BIT_ENABLE] = monitor_enable_reg;
    end
    irq_next    = supply_fault_flag_reg & monitor_irq_enable_in;
    wd_clr_next = supply_fault_flag_reg & monitor_irq_enable_in;
  end

  // Reset gives DEH with flag clear and both comparator bits high
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      monitor_enable_reg    <= SMFL_CTRL_RESET[SMFL_BIT_ENABLE];
      dtrip_reg             <= SMFL_TRIP_RESET;
      atrip_reg             <= SMFL_TRIP_RESET;
      supply_fault_flag_reg <= 1'b0;
      hold_cnt_reg          <= '0;
      holding_reg           <= 1'b0;
      rdata_reg             <= 8'h00;
      irq_reg               <= 1'b0;
      wd_clr_reg            <= 1'b0;
    end else if (clk_en_in) begin
      monitor_enable_reg    <= monitor_enable_next;
      dtrip_reg             <= dtrip_next;
      atrip_reg             <= atrip_next;
      supply_fault_flag_reg <= supply_fault_flag_next;
      hold_cnt_reg          <= hold_cnt_next;
      holding_reg           <= holding_next;
      rdata_reg             <= rdata_next;
      irq_reg               <= irq_next;
      wd_clr_reg            <= wd_clr_next;
    end
  end

  assign sfr_rdata_out             = rdata_reg;
  assign digital_trip_sel_out      = dtrip_reg;
  assign analog_trip_sel_out       = atrip_reg;
  assign comparator_enable_out     = monitor_enable_reg;
  assign supply_irq_out            = irq_reg;
  assign watchdog_enable_clear_out = wd_clr_reg;
endmodule
